// >>> src/zolnp_next_fetch_address.sv
// Zero-overhead loop control: picks the next fetch address per commit.
// Assumes commit and fetch logic share pclk; registers sit on APB.
//
// Decided for this implementation: the APB register port and the placing of the registers.

`timescale 1ns/1ps

module zolnp_next_fetch_address (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire zolnp_pkg::zolnp_commit_t commit,
    output zolnp_pkg::zolnp_fetch_t fetch,
    output logic loop_inhibit_flag
);

    // Address decode, used by both read and write paths
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        hit = (a == off);
    endfunction

    logic [31:0] loop_begin_address_q;
    logic [31:0] loop_finish_address_q;
    logic [31:0] loop_iteration_counter_q;
    logic [31:0] loop_iteration_counter_d;
    logic inhibit_q;
    logic inhibit_d;
    logic legacy_q;
    logic last_redir_q;
    logic [31:0] seq_addr;
    logic at_last;
    logic end_hit;
    logic decr;
    logic setup_active;
    logic [31:0] next_addr;
    zolnp_pkg::zolnp_cause_t next_cause;
    logic wr_go;
    logic rd_go;
    logic mapped;
    logic [31:0] rd_data;

    // Reads are muxed at setup so prdata stands in the access cycle;
    // writes land only at the access edge that completes the transfer
    assign wr_go = psel && penable && pwrite && pready;
    assign rd_go = psel && !penable && !pwrite && !pready;
    assign mapped = hit(paddr, zolnp_pkg::OFF_BEGIN)
        || hit(paddr, zolnp_pkg::OFF_FINISH)
        || hit(paddr, zolnp_pkg::OFF_COUNT)
        || hit(paddr, zolnp_pkg::OFF_STATUS)
        || hit(paddr, zolnp_pkg::OFF_CTRL);

    // Read mux; inhibit has no say here
    always_comb
    begin
        rd_data = 32'h0000_0000;
        case (1'b1)
            hit(paddr, zolnp_pkg::OFF_BEGIN):
                rd_data = loop_begin_address_q;
            hit(paddr, zolnp_pkg::OFF_FINISH):
                rd_data = loop_finish_address_q;
            hit(paddr, zolnp_pkg::OFF_COUNT):
                rd_data = loop_iteration_counter_q;
            hit(paddr, zolnp_pkg::OFF_STATUS):
            begin
                rd_data[zolnp_pkg::STAT_INHIBIT_BIT] = inhibit_q;
                rd_data[zolnp_pkg::STAT_LAST_REDIR_BIT] = last_redir_q;
            end
            hit(paddr, zolnp_pkg::OFF_CTRL):
                rd_data[zolnp_pkg::CTRL_LEGACY_BIT] = legacy_q;
            default:
                rd_data = 32'h0000_0000;
        endcase
    end

    // Bus answer: zero wait state, error on unmapped offsets
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= psel && !penable && !pready;
            pslverr <= psel && !penable && !pready && !mapped;
            prdata <= rd_go ? rd_data : 32'h0000_0000;
        end
    end

    // Loop-end detection, judged on current (old) register values
    assign seq_addr = commit.pc + 32'(commit.size);
    assign at_last = (seq_addr == loop_finish_address_q)
        && !loop_finish_address_q[zolnp_pkg::ALIGN_BIT];
    assign setup_active = commit.loop_setup && commit.cond_true;

    // Priority: trap, taken transfer, delay slot, loop end, sequential
    always_comb
    begin
        next_addr = seq_addr;
        next_cause = zolnp_pkg::ZOLNP_SEQ;
        end_hit = 1'b0;
        if (commit.exc_taken)
        begin
            next_cause = zolnp_pkg::ZOLNP_TRAP;
        end
        else if (commit.taken)
        begin
            next_addr = commit.target;
            next_cause = zolnp_pkg::ZOLNP_BRANCH;
        end
        else if (commit.loop_setup && !commit.cond_true)
        begin
            next_addr = commit.setup_target;
            next_cause = zolnp_pkg::ZOLNP_BRANCH;
        end
        else if (commit.delay_slot_flag
            && commit.branch_target_reg[zolnp_pkg::BTA_VALID_BIT])
        begin
            next_addr = commit.branch_target_reg;
            next_addr[zolnp_pkg::BTA_VALID_BIT] = 1'b0;
            next_cause = zolnp_pkg::ZOLNP_DSLOT;
        end
        else if (at_last && !inhibit_q)
        begin
            end_hit = 1'b1;
            // Earlier variant also stops at zero; later only at one
            if (loop_iteration_counter_q != zolnp_pkg::CNT_ONE
                && !(legacy_q
                && loop_iteration_counter_q == zolnp_pkg::CNT_ZERO))
            begin
                next_addr = loop_begin_address_q;
                next_cause = zolnp_pkg::ZOLNP_LOOP_BACK;
            end
            else
            begin
                next_addr = loop_finish_address_q;
                next_cause = zolnp_pkg::ZOLNP_LOOP_EXIT;
            end
        end
    end

    // Earlier variant decrements on reaching the end even if branching
    assign decr = commit.valid && !commit.exc_taken
        && (end_hit
        || (legacy_q && at_last && !inhibit_q));

    // Counter: software write lands at once, so late writes may lag
    always_comb
    begin
        loop_iteration_counter_d = loop_iteration_counter_q;
        if (wr_go && hit(paddr, zolnp_pkg::OFF_COUNT))
            loop_iteration_counter_d = pwdata;
        else if (decr)
            loop_iteration_counter_d =
                loop_iteration_counter_q - zolnp_pkg::CNT_ONE;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            loop_iteration_counter_q <= zolnp_pkg::RST_COUNT;
        else
            loop_iteration_counter_q <= loop_iteration_counter_d;
    end

    // Start and end: setup writes after its own redirect was chosen
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            loop_begin_address_q <= zolnp_pkg::RST_ADDR;
            loop_finish_address_q <= zolnp_pkg::RST_ADDR;
        end
        else if (commit.valid && !commit.exc_taken && setup_active)
        begin
            loop_begin_address_q <= seq_addr;
            loop_finish_address_q <= commit.setup_target;
        end
        else if (wr_go)
        begin
            if (hit(paddr, zolnp_pkg::OFF_BEGIN))
                loop_begin_address_q <= pwdata;
            if (hit(paddr, zolnp_pkg::OFF_FINISH))
                loop_finish_address_q <= pwdata;
        end
    end

    // Inhibit flag: trap wins over any other change
    always_comb
    begin
        inhibit_d = inhibit_q;
        if (commit.valid)
        begin
            if (commit.exc_taken)
                inhibit_d = 1'b1;
            else if (setup_active)
                inhibit_d = 1'b0;
            else if (commit.int_return && commit.kernel)
                inhibit_d = commit.saved_inhibit;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            inhibit_q <= zolnp_pkg::RST_INHIBIT;
        else
            inhibit_q <= inhibit_d;
    end

    // Variant select, software owned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            legacy_q <= zolnp_pkg::RST_LEGACY;
        else if (wr_go && hit(paddr, zolnp_pkg::OFF_CTRL))
            legacy_q <= pwdata[zolnp_pkg::CTRL_LEGACY_BIT];
    end

    // Fetch answer, one cycle after the commit it belongs to
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch <= '0;
            last_redir_q <= 1'b0;
            loop_inhibit_flag <= zolnp_pkg::RST_INHIBIT;
        end
        else
        begin
            fetch.valid <= commit.valid;
            fetch.addr <= next_addr;
            fetch.cause <= next_cause;
            if (commit.valid)
                last_redir_q <= end_hit
                    && next_cause == zolnp_pkg::ZOLNP_LOOP_BACK;
            loop_inhibit_flag <= inhibit_d;
        end
    end

    // Checks
    sequence s_loop_back;
        commit.valid && end_hit
            && next_cause == zolnp_pkg::ZOLNP_LOOP_BACK;
    endsequence

    sequence s_setup_go;
        commit.valid && !commit.exc_taken && setup_active;
    endsequence

    a_inhibit_blocks: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && inhibit_q && !legacy_q && !wr_go
        |=> $stable(loop_iteration_counter_q)
            && fetch.cause != zolnp_pkg::ZOLNP_LOOP_BACK)
        else $error("loop acted while inhibited");

    a_trap_sets: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && commit.exc_taken |=> inhibit_q ##0
            loop_inhibit_flag)
        else $error("trap did not set inhibit");

    a_setup_clears: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_setup_go |=> !inhibit_q)
        else $error("loop setup did not clear inhibit");

    a_loop_back: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_loop_back and !wr_go |=> fetch.valid
            && fetch.addr == $past(loop_begin_address_q)
            && loop_iteration_counter_q
               == $past(loop_iteration_counter_q) - 32'h0000_0001)
        else $error("loop back wrong address or count");

    a_loop_exit: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && end_hit
            && loop_iteration_counter_q == zolnp_pkg::CNT_ONE && !wr_go
        |=> fetch.addr == $past(loop_finish_address_q)
            && loop_iteration_counter_q == zolnp_pkg::CNT_ZERO)
        else $error("final pass not handled");

    a_branch_skip: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && !commit.exc_taken && commit.taken
        |=> fetch.addr == $past(commit.target)
            && fetch.cause == zolnp_pkg::ZOLNP_BRANCH)
        else $error("taken branch not followed");

    a_dslot_target: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && !commit.exc_taken && !commit.taken
            && !commit.loop_setup && commit.delay_slot_flag
            && commit.branch_target_reg[0]
        |=> fetch.cause == zolnp_pkg::ZOLNP_DSLOT)
        else $error("delay slot target ignored");

    a_odd_end: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && loop_finish_address_q[zolnp_pkg::ALIGN_BIT]
        |=> fetch.cause != zolnp_pkg::ZOLNP_LOOP_BACK
            && fetch.cause != zolnp_pkg::ZOLNP_LOOP_EXIT)
        else $error("loop end seen at odd address");

    a_setup_old: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_setup_go ##0 s_loop_back |=> fetch.addr
            == $past(loop_begin_address_q)
            && loop_begin_address_q == $past(seq_addr))
        else $error("setup update raced its redirect");

    a_reset_clear: assert property (@(posedge pclk)
        $rose(presetn) |-> !inhibit_q)
        else $error("inhibit set after reset");

    // Return from interrupt only counts when nothing stronger competes
    a_ret_restore: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && !commit.exc_taken && !setup_active
            && commit.int_return && commit.kernel
        |=> loop_inhibit_flag == $past(commit.saved_inhibit))
        else $error("interrupt return did not restore inhibit");

    a_count_write: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_go && hit(paddr, zolnp_pkg::OFF_COUNT)
        |=> loop_iteration_counter_q == $past(pwdata))
        else $error("count write lost");

    a_seq_next: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && !commit.exc_taken && !commit.taken
            && !commit.loop_setup && !commit.delay_slot_flag && !at_last
        |=> fetch.addr == $past(seq_addr)
            && fetch.cause == zolnp_pkg::ZOLNP_SEQ)
        else $error("sequential fetch address wrong");

    // Earlier variant: a branch out of the last slot still decrements
    a_legacy_exit: assert property (@(posedge pclk)
        disable iff (!presetn)
        commit.valid && !commit.exc_taken && commit.taken && legacy_q
            && at_last && !inhibit_q && !wr_go
        |=> loop_iteration_counter_q
            == $past(loop_iteration_counter_q) - zolnp_pkg::CNT_ONE)
        else $error("earlier variant exit count wrong");

    // Zero wait state: the answer never stands two cycles
    a_bus_pulse: assert property (@(posedge pclk)
        disable iff (!presetn)
        pready |=> !pready)
        else $error("bus answer held too long");

endmodule

// >>> src/zolnp_pkg.sv
// Package for the zero-overhead loop next-fetch block.
// Assumes one core clock; the commit bus comes from logic on that clock.
package zolnp_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SIZE_W = 4;

    // Register byte offsets on the bus
    localparam logic [11:0] OFF_BEGIN = 12'h000;
    localparam logic [11:0] OFF_FINISH = 12'h004;
    localparam logic [11:0] OFF_COUNT = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;
    localparam logic [11:0] OFF_CTRL = 12'h010;

    // Field positions
    localparam int unsigned STAT_INHIBIT_BIT = 0;
    localparam int unsigned STAT_LAST_REDIR_BIT = 1;
    localparam int unsigned CTRL_LEGACY_BIT = 0;
    localparam int unsigned BTA_VALID_BIT = 0;
    localparam int unsigned ALIGN_BIT = 0;

    // Reset values
    localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0000_0000;
    localparam logic [DATA_W-1:0] RST_COUNT = 32'h0000_0000;
    localparam logic RST_INHIBIT = 1'b0;
    localparam logic RST_LEGACY = 1'b0;

    // Counter values that steer the decision
    localparam logic [DATA_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [DATA_W-1:0] CNT_ZERO = 32'h0000_0000;

    // Why the next fetch address was chosen
    typedef enum logic [2:0] {
        ZOLNP_SEQ,
        ZOLNP_BRANCH,
        ZOLNP_DSLOT,
        ZOLNP_LOOP_BACK,
        ZOLNP_LOOP_EXIT,
        ZOLNP_TRAP
    } zolnp_cause_t;

    // One completing instruction, as presented by commit
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pc;
        logic [SIZE_W-1:0] size;
        logic taken;
        logic [ADDR_W-1:0] target;
        logic loop_setup;
        logic cond_true;
        logic [ADDR_W-1:0] setup_target;
        logic exc_taken;
        logic int_return;
        logic kernel;
        logic saved_inhibit;
        logic delay_slot_flag;
        logic [ADDR_W-1:0] branch_target_reg;
    } zolnp_commit_t;

    // Answer to fetch
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        zolnp_cause_t cause;
    } zolnp_fetch_t;

endpackage

// >>> test/zolnp_commit_model.sv
// Commit-side model: hands the block one completing instruction at a time.
// Assumes the block samples commit on every rising pclk edge.
`timescale 1ns/1ps
module zolnp_commit_model (
    input wire logic pclk,
    output zolnp_pkg::zolnp_commit_t commit
);
    // Nothing completes until the bench asks for it
    initial commit = '0;

    // One-cycle pulse, then fields scrambled so stale values never help
    // Only 2- or 4-byte sizes are offered: no long-immediate pair at the end
    task automatic issue(input zolnp_pkg::zolnp_commit_t x);
        @(posedge pclk);
        commit <= x;
        @(posedge pclk);
        commit <= {1'b0, ~x[$bits(x)-2:0]};
        #1;
    endtask
endmodule

// >>> test/zero_overhead_loop_next_fetch_address_tb_top.sv
// Bench for the loop next-fetch block: APB register tasks plus commits.
// Assumes the package and the commit model are compiled first.
`timescale 1ns/1ps
module zero_overhead_loop_next_fetch_address_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic inh;
    logic [31:0] r;
    logic e;
    zolnp_pkg::zolnp_commit_t commit;
    zolnp_pkg::zolnp_fetch_t fetch;
    zolnp_pkg::zolnp_commit_t c;
    int error_cnt = 0;
    int samples_checked = 0;

    // 25 MHz core clock
    always #20 pclk = ~pclk;

    zolnp_next_fetch_address dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .commit(commit), .fetch(fetch),
        .loop_inhibit_flag(inh));

    zolnp_commit_model pm (.pclk(pclk), .commit(commit));

    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            error_cnt++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task final_report;
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Setup, then access held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, x);
    endtask

    function zolnp_pkg::zolnp_commit_t mk(input logic [31:0] pc,
        input logic [3:0] sz);
        mk = '0;
        mk.valid = 1'b1;
        mk.pc = pc;
        mk.size = sz;
    endfunction

    // Commit c, then compare the answer one cycle later
    task fx(input logic [31:0] a, input zolnp_pkg::zolnp_cause_t k);
        pm.issue(c);
        chk({31'h0, fetch.valid}, 32'h1);
        chk(fetch.addr, a);
        chk({29'h0, fetch.cause}, {29'h0, k});
    endtask

    // Main sequence; every expectation is worked out by hand
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++)
            rd(12'(4 * i), 32'h0000_0000);
        chk({31'h0, inh}, 32'h0);
        wr(zolnp_pkg::OFF_STATUS, 32'hffff_ffff);
        rd(zolnp_pkg::OFF_STATUS, 32'h0000_0000);
        rd(12'h014, 32'h0000_0000);
        chk({31'h0, e}, 32'h1);
        wr(zolnp_pkg::OFF_BEGIN, 32'h0000_0100);
        wr(zolnp_pkg::OFF_FINISH, 32'h0000_0108);
        wr(zolnp_pkg::OFF_COUNT, 32'h0000_0003);
        c = mk(32'h0000_0100, 4'h4);
        fx(32'h0000_0104, zolnp_pkg::ZOLNP_SEQ);
        c = mk(32'h0000_0104, 4'h4);
        fx(32'h0000_0100, zolnp_pkg::ZOLNP_LOOP_BACK);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0002);
        rd(zolnp_pkg::OFF_STATUS, 32'h0000_0002);
        fx(32'h0000_0100, zolnp_pkg::ZOLNP_LOOP_BACK);
        fx(32'h0000_0108, zolnp_pkg::ZOLNP_LOOP_EXIT);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0000);
        wr(zolnp_pkg::OFF_COUNT, 32'h0000_0005);
        c.taken = 1'b1;
        c.target = 32'h0000_0200;
        fx(32'h0000_0200, zolnp_pkg::ZOLNP_BRANCH);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0005);
        c = mk(32'h0000_0104, 4'h4);
        c.delay_slot_flag = 1'b1;
        c.branch_target_reg = 32'h0000_0301;
        fx(32'h0000_0300, zolnp_pkg::ZOLNP_DSLOT);
        // Short instruction ending the loop, branch not taken before it
        c.pc = 32'h0000_0106;
        c.size = 4'h2;
        c.branch_target_reg = 32'h0000_0300;
        fx(32'h0000_0100, zolnp_pkg::ZOLNP_LOOP_BACK);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0004);
        c = mk(32'h0000_0104, 4'h4);
        c.exc_taken = 1'b1;
        fx(32'h0000_0108, zolnp_pkg::ZOLNP_TRAP);
        chk({31'h0, inh}, 32'h1);
        c = mk(32'h0000_0104, 4'h4);
        fx(32'h0000_0108, zolnp_pkg::ZOLNP_SEQ);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0004);
        wr(zolnp_pkg::OFF_COUNT, 32'h0000_0007);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0007);
        c = mk(32'h0000_0040, 4'h4);
        c.int_return = 1'b1;
        c.kernel = 1'b1;
        fx(32'h0000_0044, zolnp_pkg::ZOLNP_SEQ);
        chk({31'h0, inh}, 32'h0);
        c = mk(32'h0000_0040, 4'h4);
        c.exc_taken = 1'b1;
        fx(32'h0000_0044, zolnp_pkg::ZOLNP_TRAP);
        c = mk(32'h0000_0050, 4'h4);
        c.loop_setup = 1'b1;
        c.setup_target = 32'h0000_0060;
        fx(32'h0000_0060, zolnp_pkg::ZOLNP_BRANCH);
        chk({31'h0, inh}, 32'h1);
        c.cond_true = 1'b1;
        fx(32'h0000_0054, zolnp_pkg::ZOLNP_SEQ);
        chk({31'h0, inh}, 32'h0);
        rd(zolnp_pkg::OFF_BEGIN, 32'h0000_0054);
        rd(zolnp_pkg::OFF_FINISH, 32'h0000_0060);
        // Setup as last instruction: old start used, new values after
        c.pc = 32'h0000_005c;
        c.setup_target = 32'h0000_0080;
        fx(32'h0000_0054, zolnp_pkg::ZOLNP_LOOP_BACK);
        rd(zolnp_pkg::OFF_BEGIN, 32'h0000_0060);
        rd(zolnp_pkg::OFF_FINISH, 32'h0000_0080);
        wr(zolnp_pkg::OFF_BEGIN, 32'h0000_007c);
        c = mk(32'h0000_007c, 4'h4);
        fx(32'h0000_007c, zolnp_pkg::ZOLNP_LOOP_BACK);
        wr(zolnp_pkg::OFF_BEGIN, 32'h0000_0033);
        fx(32'h0000_0033, zolnp_pkg::ZOLNP_LOOP_BACK);
        wr(zolnp_pkg::OFF_FINISH, 32'h0000_0081);
        c.pc = 32'h0000_007d;
        fx(32'h0000_0081, zolnp_pkg::ZOLNP_SEQ);
        // Earlier variant: branch out of the last slot still counts
        wr(zolnp_pkg::OFF_CTRL, 32'h0000_0001);
        wr(zolnp_pkg::OFF_FINISH, 32'h0000_0080);
        wr(zolnp_pkg::OFF_COUNT, 32'h0000_0005);
        c = mk(32'h0000_007c, 4'h4);
        c.taken = 1'b1;
        c.target = 32'h0000_0200;
        fx(32'h0000_0200, zolnp_pkg::ZOLNP_BRANCH);
        rd(zolnp_pkg::OFF_COUNT, 32'h0000_0004);
        final_report;
    end

    // Whole run takes about 150 cycles; this cuts off a hang
    initial
    begin
        repeat (5000) @(posedge pclk);
        error_cnt++;
        final_report;
    end
endmodule
